// >>> xsd_addr_gen.sv
// indexed and literal-offset address generator
`timescale 1ns/1ns
module xsd_addr_gen
  import xsd_pkg::*;
#(
  parameter int               PTR_W  = 12,
  parameter logic [PTR_W-1:0] IND_LO = 12'hFD0,
  parameter logic [PTR_W-1:0] IND_HI = 12'hFEF
)(
  xsd_addr_if.gen a
);
`include "xsd_defs.svh"
  // the literal-offset adder needs at least a byte of address
  if (PTR_W < 8) begin : g_bad_width
    $error("xsd_addr_gen: PTR_W must be >= 8");
  end

  // ----------------------------------------------------------------
  // offset adder shared by both indexed forms
  // ----------------------------------------------------------------
  function automatic logic [PTR_W-1:0] add_off(input logic [PTR_W-1:0] b, input logic [7:0] o);
    return b + {{(PTR_W-8){1'b0}}, o};
  endfunction : add_off

  // the indirect window range is a plain default; set it per core map
  always_comb
  begin
    a.idx_addr     = add_off(a.frame_ptr, {1'b0, a.off});
    a.idx_is_ind   = (a.idx_addr >= IND_LO) && (a.idx_addr <= IND_HI);
    a.ilo_addr     = add_off(a.frame_ptr, a.ilo_f);
    a.ilo_in_range = (a.ilo_f <= `XSD_ILO_MAX);
  end
endmodule : xsd_addr_gen

// >>> xsd_addr_if.sv
// address bundle between the decoder and its indexed address generator
`timescale 1ns/1ns
interface xsd_addr_if #(parameter int PTR_W = 12);
  logic [PTR_W-1:0] frame_ptr;
  logic [6:0]       off;
  logic [PTR_W-1:0] idx_addr;
  logic             idx_is_ind;
  logic [7:0]       ilo_f;
  logic [PTR_W-1:0] ilo_addr;
  logic             ilo_in_range;
  modport core (output frame_ptr, off, ilo_f, input idx_addr, idx_is_ind, ilo_addr, ilo_in_range);
  modport gen  (input frame_ptr, off, ilo_f, output idx_addr, idx_is_ind, ilo_addr, ilo_in_range);
endinterface : xsd_addr_if

// >>> xsd_core.sv
// extended stack instruction decoder and executor
// Functional notes
// - extension on while config bit unprogrammed
// - eight extra instructions, only when enabled
// - pointer add literal, one cycle, flags kept
// - frame add-return takes two cycles, frame pointer
// - add to frame pointer, then return
// - second return cycle is a nop
// - selector 11 means frame-return variant
// - call via accumulator word 0014, two cycles
// - indexed moves two words, bit7 picks form
// - push literal at frame pointer, then decrement
// - pointer subtract literal, one cycle, flags kept
// - frame subtract-return, two cycles
// - access bank low addresses use frame offset
// - call pushes next address, loads pc latches
// - indirect source address reads as zero
`timescale 1ns/1ns
module xsd_core
  import xsd_pkg::*;
#(
  parameter int PTR_W = 12,
  parameter int PC_W  = 21
)(
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  input  wire logic                       extension_enable_bit,
  input  wire logic                       ins_valid,
  input  wire logic [15:0]                ins_word,
  input  wire logic [PC_W-1:0]            pc_cur,
  input  wire logic [PC_W-1:0]            return_stack_top,
  input  wire logic [7:0]                 accumulator,
  input  wire logic [7:0]                 pc_high_latch,
  input  wire logic [7:0]                 pc_upper_latch,
  input  wire logic [7:0]                 dm_rdata,
  input  wire logic                       std_valid,
  input  wire logic                       std_access_bit,
  input  wire logic [7:0]                 std_file_addr,
  output logic [2:0][PTR_W-1:0]           indirect_pointer_r,
  output logic                            dm_re_r,
  output logic [PTR_W-1:0]                dm_raddr_r,
  output logic                            dm_we_r,
  output logic [PTR_W-1:0]                dm_waddr_r,
  output logic [7:0]                      dm_wdata_r,
  output logic                            pc_load_r,
  output logic [PC_W-1:0]                 pc_load_val_r,
  output logic                            stack_push_r,
  output logic [PC_W-1:0]                 stack_push_val_r,
  output logic                            stack_pop_r,
  output logic                            fetch_discard_r,
  output logic                            ext_hit_r,
  output logic                            ilo_active_r,
  output logic [PTR_W-1:0]                ilo_addr_r
);
`include "xsd_defs.svh"
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // absolute move destinations are 12 bits wide, so the pointers must be too
  if (PTR_W != 12 || PC_W != 8 * 3 - 3) begin : g_bad_width
    $error("xsd_core: PTR_W must be 12 and PC_W must be 21");
  end

  // ----------------------------------------------------------------
  // state and address generator
  // ----------------------------------------------------------------
  xsd_state_type          st_r, st_nxt;
  logic                   ext_en_r, ext_en_nxt;
  logic [2:0][PTR_W-1:0]  ptr_nxt;
  logic                   dm_re_nxt, dm_we_nxt, pc_load_nxt, push_nxt, pop_nxt, disc_nxt, hit_nxt;
  logic [PTR_W-1:0]       raddr_nxt, waddr_nxt, ilo_addr_nxt;
  logic [7:0]             wdata_nxt;
  logic [PC_W-1:0]        pcv_nxt, pushv_nxt;
  logic                   src_ind_r, src_ind_nxt, form_r, form_nxt, ilo_nxt;
  xsd_op_type             op;
  logic                   take;
  logic [PTR_W-1:0]       k6_ext;
  logic [1:0]             sel;

  xsd_addr_if #(.PTR_W(PTR_W)) aif ();

  xsd_addr_gen #(.PTR_W(PTR_W)) u_gen (
    .a (aif.gen)
  );

  assign aif.frame_ptr = indirect_pointer_r[2];
  assign aif.off       = ins_word[6:0];
  assign aif.ilo_f     = std_file_addr;

  assign op     = xsd_decode(ins_word);
  assign take   = (st_r == ST_EXEC) && ins_valid && ext_en_r;
  assign k6_ext = {{(PTR_W-6){1'b0}}, ins_word[5:0]};
  assign sel    = ins_word[`XSD_SEL_HI:`XSD_SEL_LO];

  // ----------------------------------------------------------------
  // next-state and execution logic; no flag outputs exist, so none change
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt       = st_r;
    ext_en_nxt   = extension_enable_bit;
    ptr_nxt      = indirect_pointer_r;
    dm_re_nxt    = 1'b0;
    raddr_nxt    = dm_raddr_r;
    dm_we_nxt    = 1'b0;
    waddr_nxt    = dm_waddr_r;
    wdata_nxt    = dm_wdata_r;
    pc_load_nxt  = 1'b0;
    pcv_nxt      = pc_load_val_r;
    push_nxt     = 1'b0;
    pushv_nxt    = stack_push_val_r;
    pop_nxt      = 1'b0;
    disc_nxt     = 1'b0;
    hit_nxt      = 1'b0;
    src_ind_nxt  = src_ind_r;
    form_nxt     = form_r;
    // literal offset mode only for access-bank addresses in the low window
    ilo_nxt      = ext_en_r && std_valid && !std_access_bit && aif.ilo_in_range;
    ilo_addr_nxt = ilo_nxt ? aif.ilo_addr : ilo_addr_r;
    unique case (st_r)
      ST_EXEC:
      begin
        if (take)
        begin
          hit_nxt = (op != OP_NONE);
          unique case (op)
            OP_PTR_ADD: ptr_nxt[sel] = indirect_pointer_r[sel] + k6_ext;
            OP_PTR_SUB: ptr_nxt[sel] = indirect_pointer_r[sel] - k6_ext;
            OP_FRAME_ADD_RET, OP_FRAME_SUB_RET:
            begin
              // selector 11 always means the frame pointer plus a return
              ptr_nxt[2]  = (op == OP_FRAME_ADD_RET) ? indirect_pointer_r[2] + k6_ext
                                                     : indirect_pointer_r[2] - k6_ext;
              pc_load_nxt = 1'b1;
              pcv_nxt     = return_stack_top;
              pop_nxt     = 1'b1;
              st_nxt      = ST_NOP2;
            end
            OP_PUSH_LIT:
            begin
              dm_we_nxt  = 1'b1;
              waddr_nxt  = indirect_pointer_r[2];
              wdata_nxt  = ins_word[7:0];
              ptr_nxt[2] = indirect_pointer_r[2] - {{(PTR_W-1){1'b0}}, 1'b1};
            end
            OP_CALL_ACC:
            begin
              push_nxt    = 1'b1;
              pushv_nxt   = pc_cur + `XSD_PC_STEP;
              pc_load_nxt = 1'b1;
              pcv_nxt     = {pc_upper_latch[PC_W-17:0], pc_high_latch, accumulator};
              st_nxt      = ST_NOP2;
            end
            OP_IDX_ABS, OP_IDX_IDX:
            begin
              // source is read now; its data arrive with the second word
              dm_re_nxt   = 1'b1;
              raddr_nxt   = aif.idx_addr;
              src_ind_nxt = aif.idx_is_ind;
              form_nxt    = (op == OP_IDX_IDX);
              st_nxt      = ST_MOVE2;
            end
            default: ;
          endcase
        end
      end
      ST_MOVE2:
      begin
        if (ins_valid)
        begin
          st_nxt = ST_EXEC;
          // a malformed second word completes as a nop rather than hanging
          if (ins_word[15:12] == `XSD_SECOND_NIB)
          begin
            dm_we_nxt = 1'b1;
            waddr_nxt = form_r ? aif.idx_addr : ins_word[11:0];
            wdata_nxt = src_ind_r ? 8'h00 : dm_rdata;
          end
        end
      end
      ST_NOP2:
      begin
        disc_nxt = 1'b1;
        st_nxt   = ST_EXEC;
      end
      // the unused code falls back to exec instead of locking up
      default: st_nxt = ST_EXEC;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      st_r               <= ST_EXEC;
      ext_en_r           <= 1'b0;
      indirect_pointer_r <= {3{`XSD_PTR_RST}};
      dm_re_r            <= 1'b0;
      dm_raddr_r         <= `XSD_PTR_RST;
      dm_we_r            <= 1'b0;
      dm_waddr_r         <= `XSD_PTR_RST;
      dm_wdata_r         <= 8'h00;
      pc_load_r          <= 1'b0;
      pc_load_val_r      <= `XSD_PC_RST;
      stack_push_r       <= 1'b0;
      stack_push_val_r   <= `XSD_PC_RST;
      stack_pop_r        <= 1'b0;
      fetch_discard_r    <= 1'b0;
      ext_hit_r          <= 1'b0;
      src_ind_r          <= 1'b0;
      form_r             <= 1'b0;
      ilo_active_r       <= 1'b0;
      ilo_addr_r         <= `XSD_PTR_RST;
    end
    else
    begin
      st_r               <= st_nxt;
      ext_en_r           <= ext_en_nxt;
      indirect_pointer_r <= ptr_nxt;
      dm_re_r            <= dm_re_nxt;
      dm_raddr_r         <= raddr_nxt;
      dm_we_r            <= dm_we_nxt;
      dm_waddr_r         <= waddr_nxt;
      dm_wdata_r         <= wdata_nxt;
      pc_load_r          <= pc_load_nxt;
      pc_load_val_r      <= pcv_nxt;
      stack_push_r       <= push_nxt;
      stack_push_val_r   <= pushv_nxt;
      stack_pop_r        <= pop_nxt;
      fetch_discard_r    <= disc_nxt;
      ext_hit_r          <= hit_nxt;
      src_ind_r          <= src_ind_nxt;
      form_r             <= form_nxt;
      ilo_active_r       <= ilo_nxt;
      ilo_addr_r         <= ilo_addr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions and covers
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  ext_off_a: assert property (!ext_en_r |=> !ext_hit_r) else $error("hit while disabled");
  ptr_add_a: assert property (take && op == OP_PTR_ADD && sel == 2'b00
    |=> indirect_pointer_r[0] == $past(indirect_pointer_r[0]) + $past(k6_ext) && st_r == ST_EXEC)
    else $error("pointer add wrong");
  frame_ret_a: assert property (take && op == OP_FRAME_ADD_RET
    |=> pc_load_r && stack_pop_r && pc_load_val_r == $past(return_stack_top) ##1 fetch_discard_r && !pc_load_r)
    else $error("frame return wrong");
  frame_sub_a: assert property (take && op == OP_FRAME_SUB_RET
    |=> indirect_pointer_r[2] == $past(indirect_pointer_r[2]) - $past(k6_ext))
    else $error("frame subtract wrong");
  push_lit_a: assert property (take && op == OP_PUSH_LIT
    |=> dm_we_r && dm_waddr_r == $past(indirect_pointer_r[2])
        && indirect_pointer_r[2] == $past(indirect_pointer_r[2]) - 12'h001)
    else $error("push literal wrong");
  call_acc_a: assert property (take && op == OP_CALL_ACC
    |=> stack_push_r && stack_push_val_r == $past(pc_cur) + `XSD_PC_STEP
        && pc_load_val_r[7:0] == $past(accumulator) ##1 fetch_discard_r)
    else $error("call via accumulator wrong");
  ind_zero_a: assert property (st_r == ST_MOVE2 && ins_valid && src_ind_r && ins_word[15:12] == 4'hF
    |=> dm_we_r && dm_wdata_r == 8'h00) else $error("indirect source not zero");
  idx_dst_a: assert property (st_r == ST_MOVE2 && ins_valid && form_r && ins_word[15:12] == 4'hF
    |=> dm_waddr_r == $past(aif.idx_addr)) else $error("indexed destination wrong");
  ilo_mode_a: assert property (ext_en_r && std_valid && !std_access_bit && std_file_addr <= 8'h5F
    |=> ilo_active_r && ilo_addr_r == $past(aif.ilo_addr)) else $error("literal offset mode missed");

  move_c:   cover property (take && op == OP_IDX_IDX ##1 st_r == ST_MOVE2 ##[1:4] dm_we_r);
  ret_c:    cover property (take && op == OP_FRAME_SUB_RET ##2 fetch_discard_r);
  call_c:   cover property (take && op == OP_CALL_ACC ##1 stack_push_r);
  push_c:   cover property (take && op == OP_PUSH_LIT ##1 take && op == OP_PUSH_LIT);
endmodule : xsd_core

// >>> xsd_core_tb_top.sv
// self-checking testbench of the extended stack instruction decoder
`timescale 1ns/1ns
module xsd_core_tb_top;
  import xsd_pkg::*;
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam logic [11:0] IND_LO = 12'hFD0;  // same window as the address generator default
  localparam logic [11:0] IND_HI = 12'hFEF;
  typedef struct {
    logic [7:0]       pul;   // hit re we load push pop discard ilo
    logic             chk_hit;
    logic [11:0]      raddr, waddr, iloa;
    logic [7:0]       wdata;
    logic [20:0]      pcv, pushv;
    logic [2:0][11:0] ptr;
  } xsd_note_type;
  logic clk_sys, reset, extension_enable_bit, ins_valid, std_valid, std_access_bit;
  logic [15:0] ins_word;
  logic [20:0] pc_cur, return_stack_top, pc_load_val_r, stack_push_val_r;
  logic [7:0] accumulator, pc_high_latch, pc_upper_latch, dm_rdata, std_file_addr, dm_wdata_r;
  logic [2:0][11:0] indirect_pointer_r;
  logic [11:0] dm_raddr_r, dm_waddr_r, ilo_addr_r;
  logic dm_re_r, dm_we_r, pc_load_r, stack_push_r, stack_pop_r, fetch_discard_r, ext_hit_r, ilo_active_r;
  xsd_note_type notes[$];
  xsd_note_type nt;
  logic [2:0][11:0] ptr;
  logic [15:0] junk_words [6] = '{16'hE7C1, 16'hEC12, 16'h0013, 16'h0015, 16'h1014, 16'hF123};
  logic [31:0] seed = 32'd82627;
  int miscompares = 0;
  int tests_run = 0;
  xsd_core dut_u (.clk_sys(clk_sys), .reset(reset), .extension_enable_bit(extension_enable_bit),
    .ins_valid(ins_valid), .ins_word(ins_word), .pc_cur(pc_cur), .return_stack_top(return_stack_top),
    .accumulator(accumulator), .pc_high_latch(pc_high_latch), .pc_upper_latch(pc_upper_latch),
    .dm_rdata(dm_rdata), .std_valid(std_valid), .std_access_bit(std_access_bit),
    .std_file_addr(std_file_addr), .indirect_pointer_r(indirect_pointer_r), .dm_re_r(dm_re_r),
    .dm_raddr_r(dm_raddr_r), .dm_we_r(dm_we_r), .dm_waddr_r(dm_waddr_r), .dm_wdata_r(dm_wdata_r),
    .pc_load_r(pc_load_r), .pc_load_val_r(pc_load_val_r), .stack_push_r(stack_push_r),
    .stack_push_val_r(stack_push_val_r), .stack_pop_r(stack_pop_r), .fetch_discard_r(fetch_discard_r),
    .ext_hit_r(ext_hit_r), .ilo_active_r(ilo_active_r), .ilo_addr_r(ilo_addr_r));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic bad(input string msg);
    miscompares++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : bad
  task automatic final_report();
    $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  // blank note carries the model pointers and the given pulse pattern, zero data
  function automatic xsd_note_type blank(input logic [7:0] pul);
    xsd_note_type n;
    n = '{pul: pul, chk_hit: 1'b1, raddr: 12'h000, waddr: 12'h000, iloa: 12'h000, wdata: 8'h00,
          pcv: 21'h000000, pushv: 21'h000000, ptr: ptr};
    return n;
  endfunction : blank
  // inputs change at the falling edge; a note is queued for the next cycle
  task automatic drive(input logic v, input logic [15:0] w, input logic exp);
    @(negedge clk_sys);
    ins_valid = v;
    ins_word  = w;
    std_valid = 1'b0;
    pc_cur    = rnd();
    if (exp)
      notes.push_back(nt);
  endtask : drive
  task automatic idle(input int n);
    repeat (n) drive(1'b0, 16'h0000, 1'b0);
  endtask : idle
  task automatic ptr_op(input logic sub, input logic [1:0] f, input logic [5:0] k);
    ptr[f] = sub ? ptr[f] - 12'(k) : ptr[f] + 12'(k);
    nt = blank(8'h80);
    drive(1'b1, {sub ? 8'hE9 : 8'hE8, f, k}, 1'b1);
  endtask : ptr_op
  task automatic push_lit(input logic [7:0] k);
    nt = blank(8'hA0);
    nt.waddr = ptr[2];
    nt.wdata = k;
    ptr[2] = ptr[2] - 12'h001;
    nt.ptr = ptr;
    drive(1'b1, {8'hEA, k}, 1'b1);
  endtask : push_lit
  // the word offered in the nop cycle must be thrown away
  task automatic nop_cycle();
    nt = blank(8'h02);
    drive(1'b1, 16'hEA55, 1'b1);
  endtask : nop_cycle
  task automatic frame_ret(input logic sub, input logic [5:0] k);
    return_stack_top = rnd();
    ptr[2] = sub ? ptr[2] - 12'(k) : ptr[2] + 12'(k);
    nt = blank(8'h94);
    nt.pcv = return_stack_top;
    drive(1'b1, {sub ? 8'hE9 : 8'hE8, 2'b11, k}, 1'b1);
    nop_cycle();
  endtask : frame_ret
  task automatic call_acc();
    {accumulator, pc_high_latch, pc_upper_latch} = rnd();
    nt = blank(8'h98);
    nt.pcv = {pc_upper_latch[4:0], pc_high_latch, accumulator};
    drive(1'b1, 16'h0014, 1'b0);
    nt.pushv = pc_cur + 21'h000002;
    notes.push_back(nt);
    nop_cycle();
  endtask : call_acc
  task automatic move(input logic idx, input logic [6:0] zs, input logic [11:0] dst);
    logic [7:0] d;
    d = rnd();
    nt = blank(8'hC0);
    nt.raddr = ptr[2] + 12'(zs);
    drive(1'b1, {8'hEB, idx, zs}, 1'b1);
    nt = blank(8'h20);
    nt.chk_hit = 1'b0;
    nt.waddr = idx ? ptr[2] + 12'(dst[6:0]) : dst;
    nt.wdata = (ptr[2] + 12'(zs) >= IND_LO && ptr[2] + 12'(zs) <= IND_HI) ? 8'h00 : d;
    drive(1'b1, {4'hF, dst}, 1'b1);
    dm_rdata = d;
  endtask : move
  task automatic std_op(input logic a, input logic [7:0] f);
    @(negedge clk_sys);
    ins_valid = 1'b0;
    std_valid = 1'b1;
    std_access_bit = a;
    std_file_addr = f;
    if (extension_enable_bit && !a && f <= 8'h5F)
    begin
      nt = blank(8'h01);
      nt.chk_hit = 1'b0;
      nt.iloa = ptr[2] + 12'(f);
      notes.push_back(nt);
    end
  endtask : std_op
  // steer the frame pointer to a target through pointer add and subtract
  task automatic set_frame(input logic [11:0] t);
    logic [11:0] d;
    while (ptr[2] != t)
    begin
      d = t - ptr[2];
      if (d <= 12'd63)
        ptr_op(1'b0, 2'd2, d[5:0]);
      else
        ptr_op(1'b1, 2'd2, (12'h000 - d <= 12'd63) ? 6'(12'h000 - d) : 6'h3F);
    end
  endtask : set_frame
  // ----------------------------------------------------------------
  // clock, watchdog and result monitor
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    #(40 * 4000);
    bad("watchdog expired");
    final_report();
  end
  // every pulse seen is matched against the oldest note
  always @(negedge clk_sys)
  begin
    logic [7:0] act;
    xsd_note_type e;
    act = {ext_hit_r, dm_re_r, dm_we_r, pc_load_r, stack_push_r, stack_pop_r, fetch_discard_r, ilo_active_r};
    if (!reset && act !== 8'h00)
    begin
      tests_run++;
      if (notes.size() == 0)
        bad("output pulse with nothing pending");
      else
      begin
        e = notes.pop_front();
        if ((act & (e.chk_hit ? 8'hFF : 8'h7F)) !== e.pul) bad("pulse pattern");
        if (e.pul[6] && dm_raddr_r !== e.raddr) bad("read address");
        if (e.pul[5] && (dm_waddr_r !== e.waddr || dm_wdata_r !== e.wdata)) bad("write address or data");
        if (e.pul[4] && pc_load_val_r !== e.pcv) bad("pc load value");
        if (e.pul[3] && stack_push_val_r !== e.pushv) bad("stack push value");
        if (e.pul[0] && ilo_addr_r !== e.iloa) bad("literal offset address");
        if (indirect_pointer_r !== e.ptr) bad("pointer values");
      end
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {reset, extension_enable_bit, ins_valid, std_valid, std_access_bit} = 5'b11000;
    {ins_word, pc_cur, return_stack_top, std_file_addr, dm_rdata} = '0;
    {accumulator, pc_high_latch, pc_upper_latch} = '0;
    ptr = '0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    idle(2);
    tests_run++;
    if (indirect_pointer_r !== ptr) bad("pointers after reset");
    repeat (24) ptr_op(rnd(), 2'(rnd() % 3), rnd());
    push_lit(8'h7E);
    push_lit(8'h00);
    frame_ret(1'b0, 6'h23);
    frame_ret(1'b1, 6'h3F);
    call_acc();
    set_frame(12'h080);
    move(1'b0, 7'h05, 12'hABC);
    move(1'b1, 7'h7F, 12'h055);
    set_frame(12'hFC0);
    move(1'b1, 7'h20, 12'h003);
    move(1'b0, 7'h0F, 12'hFFF);
    move(1'b0, 7'h30, 12'h123);
    // a second word without the F nibble ends the move with no write
    nt = blank(8'hC0);
    nt.raddr = ptr[2] + 12'h001;
    drive(1'b1, 16'hEB01, 1'b1);
    drive(1'b1, 16'h0123, 1'b0);
    std_op(1'b0, 8'h5F);
    std_op(1'b0, 8'h60);
    std_op(1'b1, 8'h10);
    std_op(1'b0, 8'h00);
    foreach (junk_words[i])
      drive(1'b1, junk_words[i], 1'b0);
    extension_enable_bit = 1'b0;
    idle(2);
    drive(1'b1, 16'hEA11, 1'b0);
    drive(1'b1, 16'hE8C5, 1'b0);
    drive(1'b1, 16'h0014, 1'b0);
    std_op(1'b0, 8'h10);
    idle(1);
    extension_enable_bit = 1'b1;
    idle(2);
    ptr_op(1'b0, 2'd2, 6'h01);
    idle(3);
    tests_run++;
    if (notes.size() != 0) bad("expected results never appeared");
    final_report();
  end
endmodule : xsd_core_tb_top

// >>> xsd_defs.svh
// constants of the extended stack instruction decoder
`ifndef XSD_DEFS_SVH
`define XSD_DEFS_SVH
// ----------------------------------------------------------------
// opcode fields
// ----------------------------------------------------------------
`define XSD_OP_PTR_ADD    8'hE8
`define XSD_OP_PTR_SUB    8'hE9
`define XSD_OP_PUSH_LIT   8'hEA
`define XSD_OP_IDX_MOVE   8'hEB
`define XSD_OP_CALL_ACC   16'h0014
`define XSD_SECOND_NIB    4'hF
`define XSD_FRAME_SEL     2'h3
`define XSD_STD_COUNT     75
`define XSD_EXT_COUNT     8
// ----------------------------------------------------------------
// field positions, limits and reset values
// ----------------------------------------------------------------
`define XSD_SEL_HI        7
`define XSD_SEL_LO        6
`define XSD_FORM_BIT      7
`define XSD_ILO_MAX       8'h5F
`define XSD_PC_STEP       21'h000002
`define XSD_PTR_RST       12'h000
`define XSD_PC_RST        21'h000000
`endif

// >>> xsd_pkg.sv
// types and opcode decode of the extended stack instruction decoder
package xsd_pkg;
`include "xsd_defs.svh"
  typedef enum logic [3:0] {
    OP_NONE, OP_PTR_ADD, OP_FRAME_ADD_RET, OP_PTR_SUB, OP_FRAME_SUB_RET,
    OP_PUSH_LIT, OP_CALL_ACC, OP_IDX_ABS, OP_IDX_IDX
  } xsd_op_type;

  // gray along exec -> second word -> exec and exec -> nop -> exec; code 11 is unused
  typedef enum logic [1:0] {
    ST_EXEC  = 2'b00,
    ST_MOVE2 = 2'b01,
    ST_NOP2  = 2'b10
  } xsd_state_type;

  function automatic xsd_op_type xsd_decode(input logic [15:0] w);
    logic frame;
    frame = (w[`XSD_SEL_HI:`XSD_SEL_LO] == `XSD_FRAME_SEL);
    if (w == `XSD_OP_CALL_ACC) return OP_CALL_ACC;
    unique case (w[15:8])
      `XSD_OP_PTR_ADD:  return frame ? OP_FRAME_ADD_RET : OP_PTR_ADD;
      `XSD_OP_PTR_SUB:  return frame ? OP_FRAME_SUB_RET : OP_PTR_SUB;
      `XSD_OP_PUSH_LIT: return OP_PUSH_LIT;
      `XSD_OP_IDX_MOVE: return w[`XSD_FORM_BIT] ? OP_IDX_IDX : OP_IDX_ABS;
      default:          return OP_NONE;
    endcase
  endfunction : xsd_decode
endpackage : xsd_pkg
